// >>> rtl/etw_pkg.sv
// Shared constants and types for both ends of the two-wire serial EEPROM front end
package etw_pkg;
   // Clock and line timing
   localparam int CLK_NS = 20;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_NS = 300;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
   // Control byte and array layout
   localparam logic [3:0] CTRL_CODE = 4'hA;
   localparam int CODE_POS = 4;
   localparam int CS_POS = 1;
   localparam int CS_W = 3;
   localparam int PAGE_BITS = 4;
   localparam logic [7:0] PROT_BASE = 8'h80;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;

   typedef enum logic [4:0] {
      ETW_IDLE  = 5'h01,
      ETW_CTRL  = 5'h02,
      ETW_ADDR  = 5'h04,
      ETW_WDATA = 5'h08,
      ETW_RDATA = 5'h10
   } etw_dev_st_e;

   typedef enum logic [3:0] {
      ETW_H_IDLE  = 4'h1,
      ETW_H_START = 4'h2,
      ETW_H_BIT   = 4'h4,
      ETW_H_STOP  = 4'h8
   } etw_host_st_e;

   typedef enum logic [1:0] {
      ETW_OP_START = 2'h0,
      ETW_OP_WRITE = 2'h1,
      ETW_OP_READ  = 2'h2,
      ETW_OP_STOP  = 2'h3
   } etw_op_e;
endpackage

// >>> rtl/etw_bus_if.sv
// Two-wire bus between the master and the EEPROM slave front end
`timescale 1ns/10ps
`default_nettype none
interface etw_bus_if;
   logic scl;
   logic m_sda_oe;
   logic s_sda_oe;
   logic sda;

   // Open-drain data line with pull-up: low while either end pulls it
   assign sda = !(m_sda_oe || s_sda_oe);

   modport master (output scl, output m_sda_oe, input sda);
   modport slave (input scl, input sda, output s_sda_oe);
endinterface
`default_nettype wire

// >>> rtl/etw_dev_front.sv
// Slave end: line filtering, start/stop detection, addressing, write gating, read transmit
// Contract
// (R1) Data changes only while clock low
// (R2) Data edge with clock high is start/stop
// (R3) Slave only pulls data low or releases
// (R4) Hold transmitted data 300 ns after fall
// (R5) Reject spikes up to 50 ns on lines
// (R6) Respond only if chip-select pins match
// (R7) Write-protect high enables protection
// (R8) Low supply inhibits all writes
// (R9) Master makes clock, start and stop
// (R10) Master decides transfer direction
// (R11) Protection blocks writes to 080-0FF
// (R12) Chip-select bits follow four-bit code
// (R13) Two-flop synchronise clock and data inputs
// (R14) Straps sampled any time, assumed static
`timescale 1ns/10ps
`default_nettype none
module etw_dev_front
   import etw_pkg::*;
#(
   parameter int SPIKE = etw_pkg::SPIKE_CYC,
   parameter int HOLD = etw_pkg::HOLD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus pins
   etw_bus_if.slave bus,
   // Straps and supply monitor
   input wire logic [etw_pkg::CS_W-1:0] chip_select_pins,
   input wire logic wp,
   input wire logic supply_low,
   // Memory side
   input wire logic mem_busy,
   input wire logic [7:0] rd_data,
   output logic [7:0] rd_addr,
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic selected
);
   localparam int SPW = $clog2(SPIKE + 1);
   localparam int HW = $clog2(HOLD + 1);

   logic [1:0] raw;
   logic [1:0] flt;
   logic [1:0] prv;
   assign raw = {bus.sda, bus.scl};

   // Per line: two-flop synchroniser then a counting spike filter
   genvar g;
   for (g = 0; g < 2; g++) begin : g_line
      logic s1_q, s2_q, f_q, f_d, p_q;
      logic [SPW-1:0] c_q, c_d;
      always_comb begin
         f_d = f_q;
         c_d = '0;
         if (s2_q != f_q) begin
            // A level must outlast the spike window before it is believed
            if (c_q == SPW'(SPIKE)) begin // R5
               f_d = s2_q;
            end else begin
               c_d = c_q + 1'b1;
            end
         end
      end
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            f_q <= 1'b1;
            p_q <= 1'b1;
            c_q <= '0;
         end else begin
            s1_q <= raw[g]; // R13
            s2_q <= s1_q;
            f_q <= f_d;
            p_q <= f_q;
            c_q <= c_d;
         end
      end
      assign flt[g] = f_q;
      assign prv[g] = p_q;
   end

   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = flt[0] && !prv[0];
   assign scl_fall = !flt[0] && prv[0];
   assign start_ev = prv[0] && flt[0] && prv[1] && !flt[1]; // R2
   assign stop_ev = prv[0] && flt[0] && !prv[1] && flt[1]; // R2

   // Straps and supply monitor come from pins
   logic [CS_W-1:0] cs1_q, cs_s;
   logic wp1_q, wp_s, sup1_q, sup_s;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs1_q <= '0;
         cs_s <= '0;
         wp1_q <= 1'b1;
         wp_s <= 1'b1;
         sup1_q <= 1'b1;
         sup_s <= 1'b1;
      end else begin
         cs1_q <= chip_select_pins; // R14
         cs_s <= cs1_q;
         wp1_q <= wp;
         wp_s <= wp1_q;
         sup1_q <= supply_low;
         sup_s <= sup1_q;
      end
   end

   etw_dev_st_e st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, addr_q, addr_d;
   logic rw_q, rw_d, mack_q, mack_d, pend_q, pend_d, oe_q, oe_d, sel_q, sel_d;
   logic [HW-1:0] hold_q, hold_d;
   logic wr_stb_q, wr_stb_d;
   logic [7:0] wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
   logic blocked;

   // Protected upper half, or supply too low to program
   assign blocked = (wp_s && addr_q >= PROT_BASE) || sup_s; // R7 R8 R11

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      tx_d = tx_q;
      addr_d = addr_q;
      rw_d = rw_q;
      mack_d = mack_q;
      pend_d = pend_q;
      hold_d = hold_q;
      oe_d = oe_q;
      sel_d = sel_q;
      wr_stb_d = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      // New drive level lands only after the hold delay, well inside clock low
      if (hold_q != '0) begin // R4
         hold_d = hold_q - 1'b1;
         if (hold_q == HW'(1)) begin
            oe_d = pend_q; // R1 R3
         end
      end
      if (start_ev || stop_ev) begin // R9
         st_d = start_ev ? ETW_CTRL : ETW_IDLE;
         bit_d = '0;
         pend_d = 1'b0;
         hold_d = '0;
         oe_d = 1'b0;
         sel_d = 1'b0;
      end else if (st_q != ETW_IDLE) begin
         if (scl_rise) begin
            if (bit_q < BIT_ACK) begin
               sh_d = {sh_q[6:0], flt[1]};
            end else if (bit_q == BIT_END) begin
               // The counter already sits in the acknowledge slot at the ninth rise
               mack_d = flt[1]; // R10
            end
            if (bit_q != BIT_END) begin
               bit_d = bit_q + 1'b1;
            end
         end else if (scl_fall) begin
            hold_d = HW'(HOLD); // R4
            if (bit_q == BIT_ACK) begin
               bit_d = BIT_END;
               case (st_q)
                  ETW_CTRL: begin
                     if (sh_q[7:CODE_POS] == CTRL_CODE
                         && sh_q[CS_POS+CS_W-1:CS_POS] == cs_s && !mem_busy) begin // R6 R12
                        pend_d = 1'b1;
                        rw_d = sh_q[0]; // R10
                        sel_d = 1'b1;
                     end else begin
                        st_d = ETW_IDLE;
                        pend_d = 1'b0;
                     end
                  end
                  ETW_ADDR: begin
                     addr_d = sh_q;
                     pend_d = 1'b1;
                  end
                  ETW_WDATA: begin
                     pend_d = 1'b1;
                     // Byte is still acknowledged when the write is suppressed
                     if (!blocked) begin // R11 R8
                        wr_stb_d = 1'b1;
                        wr_addr_d = addr_q;
                        wr_data_d = sh_q;
                     end
                     addr_d = {addr_q[7:PAGE_BITS], addr_q[PAGE_BITS-1:0] + 1'b1};
                  end
                  default: begin
                     pend_d = 1'b0;
                  end
               endcase
            end else if (bit_q == BIT_END) begin
               bit_d = '0;
               pend_d = 1'b0;
               case (st_q)
                  ETW_CTRL: begin
                     if (rw_q) begin // R10
                        st_d = ETW_RDATA;
                        tx_d = rd_data;
                        pend_d = !rd_data[7];
                        addr_d = addr_q + 1'b1;
                     end else begin
                        st_d = ETW_ADDR;
                     end
                  end
                  ETW_ADDR: begin
                     st_d = ETW_WDATA;
                  end
                  ETW_RDATA: begin
                     if (mack_q) begin
                        st_d = ETW_IDLE;
                     end else begin
                        tx_d = rd_data;
                        pend_d = !rd_data[7];
                        addr_d = addr_q + 1'b1;
                     end
                  end
                  default: begin
                     pend_d = 1'b0;
                  end
               endcase
            end else if (st_q == ETW_RDATA && bit_q != '0) begin
               tx_d = {tx_q[6:0], 1'b0};
               pend_d = !tx_q[6]; // R3
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ETW_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         addr_q <= ADDR_RST;
         rw_q <= 1'b0;
         mack_q <= 1'b1;
         pend_q <= 1'b0;
         hold_q <= '0;
         oe_q <= 1'b0;
         sel_q <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_addr_q <= ADDR_RST;
         wr_data_q <= '0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         addr_q <= addr_d;
         rw_q <= rw_d;
         mack_q <= mack_d;
         pend_q <= pend_d;
         hold_q <= hold_d;
         oe_q <= oe_d;
         sel_q <= sel_d;
         wr_stb_q <= wr_stb_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
      end
   end

   assign bus.s_sda_oe = oe_q; // R3
   assign rd_addr = addr_q;
   assign wr_stb = wr_stb_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign selected = sel_q;
endmodule // etw_dev_front
`default_nettype wire

// >>> rtl/etw_host_master.sv
// Master end: makes the serial clock and runs start, byte and stop sequences
`timescale 1ns/10ps
`default_nettype none
module etw_host_master
   import etw_pkg::*;
#(
   parameter int QTR = etw_pkg::QTR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus pins
   etw_bus_if.master bus,
   // Command port
   input wire logic cmd_valid,
   input wire etw_pkg::etw_op_e cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_nack,
   output logic cmd_ready,
   // Response port
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_nack
);
   localparam int DW = $clog2(QTR + 1);

   logic s1_q, s2_q;
   etw_host_st_e st_q, st_d;
   logic [1:0] q_q, q_d;
   logic [DW-1:0] div_q, div_d;
   logic [3:0] n_q, n_d;
   logic [8:0] tx_q, tx_d, rx_q, rx_d;
   logic scl_q, scl_d, oe_q, oe_d, rdy_q, rdy_d, rv_q, rv_d, rn_q, rn_d;
   logic [7:0] rd_q, rd_d;

   // Each bus step is four equal quarters of one clock period
   always_comb begin
      st_d = st_q;
      q_d = q_q;
      div_d = div_q;
      n_d = n_q;
      tx_d = tx_q;
      rx_d = rx_q;
      scl_d = scl_q;
      oe_d = oe_q;
      rdy_d = rdy_q;
      rv_d = 1'b0;
      rn_d = rn_q;
      rd_d = rd_q;
      if (st_q == ETW_H_IDLE) begin
         div_d = DW'(QTR - 1);
         q_d = '0;
         // Ready returns one clock after reset, and with the return to idle after a finished step
         rdy_d = 1'b1;
         if (cmd_valid && rdy_q) begin
            rdy_d = 1'b0;
            scl_d = 1'b0;
            n_d = '0;
            case (cmd_op)
               ETW_OP_START: begin
                  st_d = ETW_H_START;
                  oe_d = 1'b0;
               end
               ETW_OP_STOP: begin
                  st_d = ETW_H_STOP;
                  oe_d = 1'b1;
               end
               default: begin
                  // Master picks direction; on a read it only drives its own ack
                  st_d = ETW_H_BIT; // R10
                  tx_d = (cmd_op == ETW_OP_WRITE) ? {cmd_data, 1'b1} : {8'hFF, cmd_nack};
                  oe_d = (cmd_op == ETW_OP_WRITE) ? !cmd_data[7] : 1'b0; // R1
               end
            endcase
         end
      end else if (div_q != '0) begin
         div_d = div_q - 1'b1;
      end else begin
         div_d = DW'(QTR - 1);
         q_d = q_q + 1'b1;
         case (q_q)
            2'h0: begin
               scl_d = 1'b1; // R9
            end
            2'h1: begin
               // Data moves with clock high only to mark start or stop
               if (st_q == ETW_H_START) begin
                  oe_d = 1'b1; // R2
               end else if (st_q == ETW_H_STOP) begin
                  oe_d = 1'b0; // R2
               end
            end
            2'h2: begin
               if (st_q != ETW_H_STOP) begin
                  scl_d = 1'b0;
               end
               if (st_q == ETW_H_BIT) begin
                  rx_d = {rx_q[7:0], s2_q};
               end
            end
            default: begin
               if (st_q == ETW_H_BIT && n_q != BIT_ACK) begin
                  n_d = n_q + 1'b1;
                  tx_d = {tx_q[7:0], 1'b1};
                  oe_d = !tx_q[7]; // R1
               end else begin
                  if (st_q == ETW_H_BIT) begin
                     rv_d = 1'b1;
                     rd_d = rx_q[8:1];
                     rn_d = rx_q[0];
                     oe_d = 1'b0;
                  end
                  st_d = ETW_H_IDLE;
                  rdy_d = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         st_q <= ETW_H_IDLE;
         q_q <= '0;
         div_q <= '0;
         n_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         rdy_q <= 1'b0;
         rv_q <= 1'b0;
         rn_q <= 1'b1;
         rd_q <= '0;
      end else begin
         s1_q <= bus.sda;
         s2_q <= s1_q;
         st_q <= st_d;
         q_q <= q_d;
         div_q <= div_d;
         n_q <= n_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         scl_q <= scl_d;
         oe_q <= oe_d;
         rdy_q <= rdy_d;
         rv_q <= rv_d;
         rn_q <= rn_d;
         rd_q <= rd_d;
      end
   end

   assign bus.scl = scl_q;
   assign bus.m_sda_oe = oe_q;
   assign cmd_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_data = rd_q;
   assign rsp_nack = rn_q;
endmodule // etw_host_master
`default_nettype wire

// >>> verification/etw_front_asserts.sv
// Concurrent checks on the two-wire bus between the master and slave ends
`timescale 1ns/10ps
`default_nettype none
module etw_front_asserts #(
   parameter int HOLD = 15
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus lines
   input wire logic scl,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic sda
);
   logic scl_q, scl_d;
   logic [4:0] cnt_q, cnt_d;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Cycles since the clock pin last fell, saturating so long idles never wrap
   always_comb begin
      scl_d = scl;
      cnt_d = (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
      if (scl_q && !scl) begin
         cnt_d = 5'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         cnt_q <= 5'h1F;
      end else begin
         scl_q <= scl_d;
         cnt_q <= cnt_d;
      end
   end

   a_slave_edge_low: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("slave data changed while clock high");
   a_slave_hold_delay: assert property ($changed(s_sda_oe) |-> cnt_q >= HOLD)
      else $error("slave data changed too soon after clock fall");
   a_start_by_master: assert property (($fell(sda) && scl && $past(scl)) |-> $rose(m_sda_oe))
      else $error("start condition not made by master");
   a_stop_released: assert property (($rose(sda) && scl && $past(scl)) |=> !s_sda_oe [*8])
      else $error("slave drove data after stop");
   a_drive_held: assert property ($rose(s_sda_oe) |=> s_sda_oe [*8])
      else $error("slave drive not held");
   // Slave answer lands after sync, filter and hold, well before the next rise
   a_answer_in_time: assert property ($changed(s_sda_oe) |-> cnt_q <= HOLD + 8)
      else $error("slave data change came too late after clock fall");
   a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
      else $error("clock high phase too short");
   a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
      else $error("clock low phase too short");

   c_start: cover property ($fell(sda) && scl && $past(scl));
   c_slave_drive: cover property ($rose(s_sda_oe));
   c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule // etw_front_asserts
`default_nettype wire

// >>> verification/tb_eeprom_twowire_slave_front.sv
// Bench joining the master and slave ends, plus a bit-banged second bus
`timescale 1ns/10ps
`default_nettype none
module tb_eeprom_twowire_slave_front;
   import etw_pkg::*;
   localparam int Q = 25;
   logic clk, reset_n, cmd_valid, cmd_nack, cmd_ready, rsp_valid, rsp_nack;
   logic wp, supply_low, mem_busy, wr_stb, selected, sel2;
   etw_op_e cmd_op;
   logic [7:0] cmd_data, rsp_data, rd_addr, rd_data, wr_addr, wr_data;
   logic [2:0] cs;
   logic [7:0] mem [256];
   int n_fail, checks, n_wr;
   etw_bus_if bus();
   etw_bus_if bus2();

   etw_host_master #(.QTR(Q)) etw_host_master_inst (.clk(clk), .reset_n(reset_n),
      .bus(bus.master), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   etw_dev_front etw_dev_front_inst (.clk(clk), .reset_n(reset_n), .bus(bus.slave),
      .chip_select_pins(cs), .wp(wp), .supply_low(supply_low), .mem_busy(mem_busy),
      .rd_data(rd_data), .rd_addr(rd_addr), .wr_stb(wr_stb), .wr_addr(wr_addr),
      .wr_data(wr_data), .selected(selected));
   // Second slave on a bus driven by the bench, for noisy-line stimulus
   etw_dev_front etw_dev_front_inst2 (.clk(clk), .reset_n(reset_n), .bus(bus2.slave),
      .chip_select_pins(cs), .wp(wp), .supply_low(supply_low), .mem_busy(mem_busy),
      .rd_data(rd_data), .rd_addr(), .wr_stb(), .wr_addr(), .wr_data(), .selected(sel2));
   etw_front_asserts #(.HOLD(HOLD_CYC)) etw_front_asserts_inst (.clk(clk),
      .reset_n(reset_n), .scl(bus.scl), .m_sda_oe(bus.m_sda_oe),
      .s_sda_oe(bus.s_sda_oe), .sda(bus.sda));

   assign rd_data = mem[rd_addr];
   always @(posedge clk) begin
      if (!reset_n) begin
         n_wr <= 0;
         for (int i = 0; i < 256; i++) mem[i] <= i[7:0] ^ 8'h3C;
      end else if (wr_stb === 1'b1) begin
         mem[wr_addr] <= wr_data;
         n_wr <= n_wr + 1;
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Ready is judged at the falling edge so the taking edge sees a settled value
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 3000);
      if (cmd_ready !== 1'b1) begin
         n_fail++;
         $display("[ERR] cmd_ready expected 1 seen %b", cmd_ready);
         stop_test();
      end
   endtask

   task automatic op(input etw_op_e o, input logic [7:0] d, input logic nk);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op <= o;
      cmd_data <= d;
      cmd_nack <= nk;
      wait_rdy();
      @(posedge clk);
      cmd_valid <= 1'b0;
      wait_rdy();
   endtask

   task automatic wr_byte(input logic [7:0] d, input logic nk);
      op(ETW_OP_WRITE, d, 1'b0);
      chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
      chk("ack", {7'h00, nk}, {7'h00, rsp_nack});
   endtask

   task automatic wr_one(input logic [7:0] a, input logic [7:0] d);
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({CTRL_CODE, cs, 1'b0}, 1'b0);
      wr_byte(a, 1'b0);
      wr_byte(d, 1'b0);
      op(ETW_OP_STOP, 8'h00, 1'b0);
   endtask

   // Page write crossing the end of a 16-byte row wraps to its start
   task automatic t_write();
      int w0;
      w0 = n_wr;
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({CTRL_CODE, cs, 1'b0}, 1'b0);
      wr_byte(8'h1F, 1'b0);
      wr_byte(8'h5A, 1'b0);
      wr_byte(8'hA5, 1'b0);
      op(ETW_OP_STOP, 8'h00, 1'b0);
      chk("wr_cnt", 8'h02, 8'(n_wr - w0));
      chk("mem_1f", 8'h5A, mem[8'h1F]);
      chk("mem_10", 8'hA5, mem[8'h10]);
   endtask

   task automatic t_read();
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({CTRL_CODE, cs, 1'b0}, 1'b0);
      wr_byte(8'h1F, 1'b0);
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({CTRL_CODE, cs, 1'b1}, 1'b0);
      op(ETW_OP_READ, 8'h00, 1'b0);
      chk("rd_1f", 8'h5A, rsp_data);
      op(ETW_OP_READ, 8'h00, 1'b1);
      chk("rd_20", 8'h20 ^ 8'h3C, rsp_data);
      op(ETW_OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic t_select();
      for (int i = 0; i < 8; i++) begin
         op(ETW_OP_START, 8'h00, 1'b0);
         wr_byte({CTRL_CODE, i[2:0], 1'b0}, i[2:0] != cs);
         chk("selected", {7'h00, i[2:0] == cs}, {7'h00, selected});
         op(ETW_OP_STOP, 8'h00, 1'b0);
      end
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({4'hB, cs, 1'b0}, 1'b1);
      @(posedge clk) mem_busy <= 1'b1;
      op(ETW_OP_START, 8'h00, 1'b0);
      wr_byte({CTRL_CODE, cs, 1'b0}, 1'b1);
      op(ETW_OP_STOP, 8'h00, 1'b0);
      @(posedge clk) mem_busy <= 1'b0;
   endtask

   task automatic t_protect();
      @(posedge clk) wp <= 1'b1;
      wr_one(8'h90, 8'h11);
      wr_one(8'h7F, 8'h22);
      chk("prot_hi", 8'h90 ^ 8'h3C, mem[8'h90]);
      chk("prot_lo", 8'h22, mem[8'h7F]);
      @(posedge clk) begin
         wp <= 1'b0;
         supply_low <= 1'b1;
      end
      wr_one(8'h30, 8'h33);
      chk("supply", 8'h30 ^ 8'h3C, mem[8'h30]);
      @(posedge clk) supply_low <= 1'b0;
   endtask

   // One bit on the second bus: a 40 ns clock spike while low, a data spike while high
   task automatic b2(input logic d, output logic s);
      repeat (Q) @(posedge clk);
      bus2.m_sda_oe <= !d;
      repeat (Q) @(posedge clk);
      bus2.scl <= 1'b1;
      repeat (2) @(posedge clk);
      bus2.scl <= 1'b0;
      repeat (Q) @(posedge clk);
      bus2.scl <= 1'b1;
      repeat (Q) @(posedge clk);
      s = bus2.sda;
      bus2.m_sda_oe <= d;
      repeat (2) @(posedge clk);
      bus2.m_sda_oe <= !d;
      repeat (Q) @(posedge clk);
      bus2.scl <= 1'b0;
   endtask

   task automatic t_spike();
      logic s;
      logic [7:0] c;
      c = {CTRL_CODE, cs, 1'b0};
      @(posedge clk) bus2.m_sda_oe <= 1'b1;
      repeat (Q) @(posedge clk);
      bus2.scl <= 1'b0;
      for (int i = 7; i >= 0; i--) b2(c[i], s);
      b2(1'b1, s);
      chk("spike_ack", 8'h00, {7'h00, s});
      chk("spike_sel", 8'h01, {7'h00, sel2});
      repeat (Q) @(posedge clk);
      bus2.m_sda_oe <= 1'b1;
      repeat (Q) @(posedge clk);
      bus2.scl <= 1'b1;
      repeat (Q) @(posedge clk);
      bus2.m_sda_oe <= 1'b0;
      repeat (Q) @(posedge clk);
      chk("stop_sel", 8'h00, {7'h00, sel2});
   endtask

   initial begin
      n_fail = 0;
      checks = 0;
      reset_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = ETW_OP_START;
      cmd_data = 8'h00;
      cmd_nack = 1'b0;
      cs = 3'h5;
      wp = 1'b0;
      supply_low = 1'b0;
      mem_busy = 1'b0;
      bus2.scl = 1'b1;
      bus2.m_sda_oe = 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_write();
      t_read();
      t_select();
      t_protect();
      t_spike();
      stop_test();
   end
endmodule // tb_eeprom_twowire_slave_front
`default_nettype wire
